// [shared/baie_consts.vh]
// Purpose: constants for the branch and increment execution block
// Assumes: 14-bit instruction word, four-phase instruction cycle
// Notes: phase codes are one-hot-free binary counts 0..3
`ifndef BAIE_CONSTS_VH
`define BAIE_CONSTS_VH
`define BAIE_JMP_OP_HI    13
`define BAIE_JMP_OP_LO    11
`define BAIE_JMP_OPCODE   3'h5
`define BAIE_INC_OP_HI    13
`define BAIE_INC_OP_LO    8
`define BAIE_INC_OPCODE   6'h0a
`define BAIE_LIT_HI       10
`define BAIE_DEST_BIT     7
`define BAIE_ADDR_HI      6
`define BAIE_LATCH_HI     4
`define BAIE_LATCH_LO     3
`define BAIE_Q1           2'h0
`define BAIE_Q2           2'h1
`define BAIE_Q3           2'h2
`define BAIE_Q4           2'h3
`endif

// [hdl/baie_exec.v]
// Purpose: execute unconditional jump and file increment instructions
// Assumes: instr_i valid from q1 of each instruction cycle; file read
//          data answers file_addr_o combinationally
// Notes: one ref_clk_i edge per phase, four phases per instruction cycle
`timescale 1ns/100ps
`default_nettype none
`include "baie_consts.vh"
module baie_exec #(
  parameter PC_W = 13
) (
  input  wire             ref_clk_i,
  input  wire             reset_n_i,
  input  wire [13:0]      instr_i,
  input  wire [7:0]       page_latch_i,
  input  wire [7:0]       file_rdata_i,
  output wire [1:0]       phase_o,
  output wire             busy_o,
  output wire [6:0]       file_addr_o,
  output reg  [7:0]       file_wdata_o,
  output reg              file_we_o,
  output reg  [7:0]       w_wdata_o,
  output reg              w_we_o,
  output reg              zero_o,
  output reg              zero_we_o,
  output reg  [PC_W-1:0]  pc_o,
  output reg              pc_we_o
);
  reg [1:0]       phase_ff;
  reg             nop_ff;     // second jump cycle
  reg             is_jmp_ff;
  reg             is_inc_ff;
  reg             dest_ff;
  reg [6:0]       addr_ff;
  reg [10:0]      lit_ff;
  reg [7:0]       data_ff;
  reg [PC_W-1:0]  target_ff;
  reg [7:0]       sum_ff;

  wire dec_jmp = (instr_i[`BAIE_JMP_OP_HI:`BAIE_JMP_OP_LO] ==
                  `BAIE_JMP_OPCODE);
  wire dec_inc = (instr_i[`BAIE_INC_OP_HI:`BAIE_INC_OP_LO] ==
                  `BAIE_INC_OPCODE);

  assign phase_o     = phase_ff;
  assign busy_o      = nop_ff;
  assign file_addr_o = addr_ff;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_ff     <= 2'h0;
      nop_ff       <= 1'b0;
      is_jmp_ff    <= 1'b0;
      is_inc_ff    <= 1'b0;
      dest_ff      <= 1'b0;
      addr_ff      <= 7'h00;
      lit_ff       <= 11'h000;
      data_ff      <= 8'h00;
      target_ff    <= {PC_W{1'b0}};
      sum_ff       <= 8'h00;
      file_wdata_o <= 8'h00;
      file_we_o    <= 1'b0;
      w_wdata_o    <= 8'h00;
      w_we_o       <= 1'b0;
      zero_o       <= 1'b0;
      zero_we_o    <= 1'b0;
      pc_o         <= {PC_W{1'b0}};
      pc_we_o      <= 1'b0;
    end else begin
      phase_ff  <= phase_ff + 2'h1;
      file_we_o <= 1'b0;
      w_we_o    <= 1'b0;
      zero_we_o <= 1'b0;
      pc_we_o   <= 1'b0;
      case (phase_ff)
        `BAIE_Q1: begin
          // idle second jump cycle decodes nothing
          if (nop_ff) begin
            is_jmp_ff <= 1'b0;
            is_inc_ff <= 1'b0;
          end else begin
            is_jmp_ff <= dec_jmp;
            is_inc_ff <= dec_inc;
            dest_ff   <= instr_i[`BAIE_DEST_BIT];
            addr_ff   <= instr_i[`BAIE_ADDR_HI:0];
            lit_ff    <= instr_i[`BAIE_LIT_HI:0];
          end
        end
        `BAIE_Q2: begin
          if (is_inc_ff)
            data_ff <= file_rdata_i;
        end
        `BAIE_Q3: begin
          if (is_jmp_ff)
            target_ff <= {page_latch_i[`BAIE_LATCH_HI:`BAIE_LATCH_LO],
                          lit_ff};
          if (is_inc_ff)
            sum_ff <= data_ff + 8'h01;
        end
        `BAIE_Q4: begin
          // jump writes the pc and sets nop_ff (busy_o), never the zero flag
          if (is_jmp_ff) begin
            pc_o    <= target_ff;
            pc_we_o <= 1'b1;
          end
          nop_ff <= is_jmp_ff;
          if (is_inc_ff) begin
            zero_o    <= (sum_ff == 8'h00);
            zero_we_o <= 1'b1;
            if (dest_ff) begin
              file_wdata_o <= sum_ff;
              file_we_o    <= 1'b1;
            end else begin
              w_wdata_o <= sum_ff;
              w_we_o    <= 1'b1;
            end
          end
        end
        default: begin
          phase_ff <= 2'h0;
        end
      endcase
    end
  end
endmodule // baie_exec
`default_nettype wire

// [tb/baie_exec_chk.sv]
// Purpose: port assertions for the jump and increment executor
// Assumes: one clock edge per phase, four phases per instruction
// Notes: watches write strobes and the zero flag against the written data, other data checked by the bench
`timescale 1ns/100ps
`default_nettype none
module baie_exec_chk (
  input wire logic       ref_clk_i, reset_n_i, busy_o, pc_we_o,
  input wire logic       file_we_o, w_we_o, zero_o, zero_we_o,
  input wire logic [1:0] phase_o,
  input wire logic [7:0] w_wdata_o,
  input wire logic [7:0] file_wdata_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence idle_s; busy_o [*4] ##1 !busy_o; endsequence
  jump_idle_a: assert property ($rose(busy_o) |-> idle_s)
    else $error("jump idle cycle length wrong");
  jump_write_a: assert property (pc_we_o |->
    busy_o && phase_o == 2'h0) else $error("pc write outside q4 end");
  jump_flags_a: assert property (pc_we_o |-> !zero_we_o)
    else $error("jump touched zero flag");
  idle_quiet_a: assert property (busy_o && $past(busy_o) |->
    !(pc_we_o || w_we_o || file_we_o || zero_we_o)) else $error("idle write");
  inc_phase_a: assert property (w_we_o || file_we_o |->
    zero_we_o && phase_o == 2'h0) else $error("increment write misplaced");
  inc_zero_a: assert property (zero_we_o && w_we_o |->
    zero_o == (w_wdata_o == 8'h00)) else $error("zero flag wrong");
  file_zero_a: assert property (zero_we_o && file_we_o |->
    zero_o == (file_wdata_o == 8'h00)) else $error("file zero flag wrong");
  one_dest_a: assert property (w_we_o |-> !file_we_o)
    else $error("both destinations written");
  inc_once_a: assert property (zero_we_o |-> (w_we_o || file_we_o)
    ##1 !zero_we_o [*3]) else $error("flag write not once per cycle");
endmodule // baie_exec_chk
bind baie_exec baie_exec_chk u_chk (.*);
`default_nettype wire

// [tb/tb_baie_exec.sv]
// Purpose: self-checking bench for the jump and increment executor
// Assumes: 50 ns clock, one edge per phase
// Notes: each instruction is preceded by one cycle holding the previous op's next word, a nop except 14'h0aff after the jump
`timescale 1ns/100ps
`default_nettype none
module tb_baie_exec;
  logic        ref_clk_i = 1'b0, reset_n_i = 1'b0;
  logic [13:0] instr_i = 14'h0;
  logic [7:0]  rd = 8'h0;
  wire  [41:0] o;
  int          fails = 0, check_count = 0, cyc = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  // one vector of outputs keeps expectations to a single literal each
  baie_exec DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .instr_i(instr_i), .page_latch_i(rd), .file_rdata_i(rd), .phase_o(),
    .pc_o(o[12:0]), .w_wdata_o(o[20:13]), .file_wdata_o(o[28:21]),
    .file_addr_o(o[35:29]), .busy_o(o[36]), .pc_we_o(o[37]),
    .zero_o(o[38]), .zero_we_o(o[39]), .w_we_o(o[40]), .file_we_o(o[41]));
  task summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [41:0] s, e);
    check_count++;
    if (s !== e) fails++;
    if (s !== e) $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
  endtask
  task op(input logic [13:0] i, n, input logic [7:0] r, input logic [41:0] e);
    repeat (4) @(posedge ref_clk_i);
    {instr_i, rd} <= {i, r};
    repeat (4) @(posedge ref_clk_i);
    instr_i <= n;
    #1;
    chk(o, e);
    $display("op %h checked", i);
  endtask
  task inc_wrap;
    op(14'h0aff, 14'h0, 8'hff, {6'h2c, 7'h7f, 29'h0});
  endtask
  task inc_w;
    op(14'h0a00, 14'h0, 8'h41, {6'h18, 15'h0, 8'h42, 13'h0});
  endtask
  task jump;
    op(14'h2d55, 14'h0aff, 8'hef,
      {6'h03, 7'h55, 8'h00, 8'h42, 13'h0d55});
  endtask
  task idle_after_jump;
    op(14'h0, 14'h0, 8'h0, {21'h0, 8'h42, 13'h0d55});
  endtask
  // upper page bit set, lower clear, so both latch bits are seen apart
  task jump_high_page;
    op(14'h2aaa, 14'h0, 8'h10,
      {6'h03, 7'h2a, 8'h00, 8'h42, 13'h12aa});
  endtask
  always @(posedge ref_clk_i) if (++cyc > 100) begin
    fails++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    inc_wrap;
    inc_w;
    jump;
    idle_after_jump;
    jump_high_page;
    summarize;
  end
endmodule // tb_baie_exec
`default_nettype wire
